// ---- rtl/dct_tag_ctrl.sv ----
// Data cache tag, state, lock and FIFO replacement controller.
// Assumes the load/store pipeline holds a request until req_ready and the bus
// interface moves whole lines, pulsing wb_done and fill_word_valid.
module dct_tag_ctrl (
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire logic                         req_write,
  input  wire logic [dct_pkg::VA_W-1:0]     req_vaddr,
  input  wire logic [dct_pkg::PA_W-1:0]     req_paddr,
  input  wire logic                         req_write_through,
  input  wire logic                         req_write_allocate,
  input  wire logic [2:0]                   req_op,
  input  wire logic [1:0]                   req_op_way,
  input  wire logic [dct_pkg::WAY_W-1:0]    tag_staging_register,
  output logic                              resp_valid,
  output logic                              resp_hit,
  output logic [1:0]                        resp_way,
  output logic [dct_pkg::WAYS-1:0]          resp_store_ways,
  output logic                              mem_write,
  output logic                              wb_req,
  input  wire logic                         wb_done,
  output logic [1:0]                        wb_way,
  output logic [dct_pkg::IDX_W-1:0]         wb_index,
  output logic [dct_pkg::PHYSICAL_TAG_FIELD_W-1:0]        wb_physical_tag_field,
  output logic                              fill_req,
  input  wire logic                         fill_word_valid,
  output logic [1:0]                        fill_way,
  output logic [dct_pkg::IDX_W-1:0]         fill_index,
  output logic [dct_pkg::PHYSICAL_TAG_FIELD_W-1:0]        fill_physical_tag_field,
  output logic [dct_pkg::CNT_W-1:0]         fill_word_sel
);
  typedef struct packed {
    dct_pkg::dct_state_t             st;
    logic [dct_pkg::IDX_W-1:0]       idx;
    logic [dct_pkg::PHYSICAL_TAG_FIELD_W-1:0]      physical_tag_field;
    logic [2:0]                      op;
    logic [1:0]                      op_way;
    logic [dct_pkg::WAY_W-1:0]       stage;
    logic                            wr;
    logic                            wt;
    logic                            alloc;
    logic [dct_pkg::SET_W-1:0]       pend;
    logic [1:0]                      vway;
    logic [dct_pkg::PHYSICAL_TAG_FIELD_W-1:0]      old_physical_tag_field;
    logic [dct_pkg::CNT_W-1:0]       cnt;
    logic                            resp_valid;
    logic                            resp_hit;
    logic [1:0]                      resp_way;
    logic [dct_pkg::WAYS-1:0]        resp_ways;
    logic                            mem_write;
  } dct_regs_t;

  dct_regs_t                    r;
  dct_regs_t                    next_r;
  logic                         rd_en;
  logic [dct_pkg::IDX_W-1:0]    rd_addr;
  logic [dct_pkg::SET_W-1:0]    rd_data;
  logic                         wr_en;
  logic [dct_pkg::IDX_W-1:0]    wr_addr;
  logic [dct_pkg::SET_W-1:0]    wr_data;
  logic [dct_pkg::WAY_W-1:0]    ent [dct_pkg::WAYS];
  logic [dct_pkg::WAYS-1:0]     hit;
  logic [dct_pkg::WAYS-1:0]     inv;

  // Way 0 has no lock bit in storage, so it always reads back unlocked
  function automatic logic [dct_pkg::WAY_W-1:0] get_way(
    input logic [dct_pkg::SET_W-1:0] s,
    input logic [1:0]                w
  );
    logic [dct_pkg::WAY_W-1:0] e;
    e = '0;
    unique case (w)
      2'h0: e = {s[dct_pkg::WAY0_W-1:dct_pkg::LOCK_BIT], 1'b0,
                 s[dct_pkg::WB_BIT:0]};
      2'h1: e = s[dct_pkg::WAY1_LSB +: dct_pkg::WAY_W];
      2'h2: e = s[dct_pkg::WAY2_LSB +: dct_pkg::WAY_W];
      2'h3: e = s[dct_pkg::WAY3_LSB +: dct_pkg::WAY_W];
    endcase
    return e;
  endfunction : get_way

  function automatic logic [dct_pkg::SET_W-1:0] put_way(
    input logic [dct_pkg::SET_W-1:0] s,
    input logic [1:0]                w,
    input logic [dct_pkg::WAY_W-1:0] e
  );
    logic [dct_pkg::SET_W-1:0] n;
    n = s;
    unique case (w)
      2'h0: n[dct_pkg::WAY0_W-1:0] = {e[dct_pkg::WAY_W-1:dct_pkg::PHYSICAL_TAG_FIELD_LSB],
                                      e[dct_pkg::WB_BIT:0]};
      2'h1: n[dct_pkg::WAY1_LSB +: dct_pkg::WAY_W] = e;
      2'h2: n[dct_pkg::WAY2_LSB +: dct_pkg::WAY_W] = e;
      2'h3: n[dct_pkg::WAY3_LSB +: dct_pkg::WAY_W] = e;
    endcase
    return n;
  endfunction : put_way

  function automatic logic is_valid(input logic [dct_pkg::WAY_W-1:0] e);
    return e[dct_pkg::CS_LSB +: 2] == dct_pkg::CS_VALID;
  endfunction : is_valid

  // Scan from the current pointer so the first invalid way in FIFO order wins
  function automatic logic [1:0] pick_victim(
    input logic [dct_pkg::WAYS-1:0] invalid,
    input logic [1:0]               ptr
  );
    logic [1:0] v;
    logic       found;
    logic [1:0] c;
    v = ptr;
    found = 1'b0;
    for (int i = 0; i < dct_pkg::WAYS; i++)
    begin
      c = ptr + 2'(i);
      if (!found && invalid[c])
      begin
        v = c;
        found = 1'b1;
      end
    end
    return v;
  endfunction : pick_victim

  // Way 0 is never locked, so the scan always lands somewhere legal
  function automatic logic [dct_pkg::SET_W-1:0] advance_fifo(
    input logic [dct_pkg::SET_W-1:0] s,
    input logic [1:0]                base
  );
    logic [dct_pkg::SET_W-1:0]  n;
    logic [dct_pkg::WAY_W-1:0]  e;
    logic                       found;
    logic [1:0]                 c;
    n = s;
    found = 1'b0;
    for (int i = 1; i <= dct_pkg::WAYS; i++)
    begin
      c = base + 2'(i);
      e = get_way(s, c);
      if (!found && !(e[dct_pkg::LOCK_BIT] && is_valid(e)))
      begin
        n[dct_pkg::FIFO_PTR_HIGH_BIT:dct_pkg::FIFO_PTR_LOW_BIT] = c;
        found = 1'b1;
      end
    end
    return n;
  endfunction : advance_fifo

  function automatic logic [1:0] lowest(input logic [dct_pkg::WAYS-1:0] m);
    logic [1:0] w;
    w = 2'h0;
    for (int i = dct_pkg::WAYS - 1; i >= 0; i--)
    begin
      if (m[i])
      begin
        w = 2'(i);
      end
    end
    return w;
  endfunction : lowest

  dct_tag_ram #(
    .WIDTH (dct_pkg::SET_W),
    .DEPTH (dct_pkg::DEPTH),
    .AW    (dct_pkg::IDX_W)
  ) u_ram (
    .clk     (clk),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .rd_en   (rd_en),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  for (genvar w = 0; w < dct_pkg::WAYS; w++)
  begin : g_way
    assign ent[w] = get_way(rd_data, 2'(w));
    assign hit[w] = is_valid(ent[w])
                    && ent[w][dct_pkg::PHYSICAL_TAG_FIELD_LSB +: dct_pkg::PHYSICAL_TAG_FIELD_W] == r.physical_tag_field;
    assign inv[w] = !is_valid(ent[w]);
  end

  always_comb
  begin
    logic [1:0]                v;
    logic [dct_pkg::WAY_W-1:0] e;
    logic [dct_pkg::SET_W-1:0] s;
    v = pick_victim(inv, rd_data[dct_pkg::FIFO_PTR_HIGH_BIT:dct_pkg::FIFO_PTR_LOW_BIT]);
    e = '0;
    s = rd_data;
    next_r = r;
    next_r.resp_valid = 1'b0;
    next_r.mem_write = 1'b0;
    rd_en = 1'b0;
    rd_addr = req_vaddr[dct_pkg::IDX_LSB +: dct_pkg::IDX_W];
    wr_en = 1'b0;
    wr_addr = r.idx;
    wr_data = r.pend;
    unique case (r.st)
      dct_pkg::ST_CLEAR:
      begin
        wr_en = 1'b1;
        wr_data = '0;
        next_r.idx = r.idx + 8'h01;
        if (r.idx == 8'(dct_pkg::DEPTH - 1))
        begin
          next_r.st = dct_pkg::ST_IDLE;
        end
      end
      dct_pkg::ST_IDLE:
      begin
        if (req_valid)
        begin
          rd_en = 1'b1;
          next_r.idx = req_vaddr[dct_pkg::IDX_LSB +: dct_pkg::IDX_W];
          next_r.physical_tag_field = req_paddr[dct_pkg::PA_TAG_LSB +: dct_pkg::PHYSICAL_TAG_FIELD_W];
          next_r.wr = req_write;
          next_r.wt = req_write_through;
          next_r.alloc = req_write_allocate;
          next_r.op = req_op;
          next_r.op_way = req_op_way;
          next_r.stage = tag_staging_register;
          next_r.st = dct_pkg::ST_LOOK;
        end
      end
      dct_pkg::ST_LOOK:
      begin
        next_r.st = dct_pkg::ST_IDLE;
        next_r.resp_hit = |hit;
        next_r.resp_way = lowest(hit);
        next_r.resp_ways = hit;
        next_r.cnt = '0;
        if (r.op == dct_pkg::OP_INDEX_STORE_TAG)
        begin
          e = r.stage;
          if (r.op_way == 2'h0)
          begin
            e[dct_pkg::LOCK_BIT] = 1'b0;
          end
          wr_en = 1'b1;
          wr_data = advance_fifo(put_way(rd_data, r.op_way, e), r.op_way);
          next_r.resp_valid = 1'b1;
        end
        else if (r.op == dct_pkg::OP_HIT_INV)
        begin
          for (int i = 0; i < dct_pkg::WAYS; i++)
          begin
            e = get_way(s, 2'(i));
            if (hit[i])
            begin
              e[dct_pkg::CS_LSB +: 2] = dct_pkg::CS_INVALID;
              e[dct_pkg::WB_BIT] = 1'b0;
              s = put_way(s, 2'(i), e);
            end
          end
          wr_en = 1'b1;
          wr_data = advance_fifo(s, lowest(hit));
          next_r.resp_valid = 1'b1;
        end
        else if (r.op == dct_pkg::OP_INDEX_WB_INV)
        begin
          e = ent[r.op_way];
          e[dct_pkg::CS_LSB +: 2] = dct_pkg::CS_INVALID;
          e[dct_pkg::WB_BIT] = 1'b0;
          next_r.pend = advance_fifo(put_way(rd_data, r.op_way, e), r.op_way);
          next_r.vway = r.op_way;
          next_r.old_physical_tag_field = ent[r.op_way][dct_pkg::PHYSICAL_TAG_FIELD_LSB +: dct_pkg::PHYSICAL_TAG_FIELD_W];
          if (is_valid(ent[r.op_way]) && ent[r.op_way][dct_pkg::WB_BIT])
          begin
            next_r.st = dct_pkg::ST_WB;
          end
          else
          begin
            wr_en = 1'b1;
            wr_data = next_r.pend;
            next_r.resp_valid = 1'b1;
          end
        end
        else if (r.op == dct_pkg::OP_NONE && (|hit) && !r.wr)
        begin
          next_r.resp_valid = 1'b1;
        end
        else if (r.op == dct_pkg::OP_NONE && (|hit))
        begin
          // Every hitting way takes the store, locked or not
          for (int i = 0; i < dct_pkg::WAYS; i++)
          begin
            e = get_way(s, 2'(i));
            if (hit[i])
            begin
              e[dct_pkg::WB_BIT] = 1'b1;
              s = put_way(s, 2'(i), e);
            end
          end
          wr_en = 1'b1;
          wr_data = s;
          next_r.mem_write = r.wt;
          next_r.resp_valid = 1'b1;
        end
        else if (r.op == dct_pkg::OP_NONE && r.wr && r.wt && !r.alloc)
        begin
          next_r.mem_write = 1'b1;
          next_r.resp_valid = 1'b1;
        end
        else
        begin
          // Miss or fill: refill the victim, keeping its lock enable
          e = '0;
          e[dct_pkg::PHYSICAL_TAG_FIELD_LSB +: dct_pkg::PHYSICAL_TAG_FIELD_W] = r.physical_tag_field;
          e[dct_pkg::CS_LSB +: 2] = dct_pkg::CS_VALID;
          e[dct_pkg::WB_BIT] = r.wr && r.op == dct_pkg::OP_NONE;
          e[dct_pkg::LOCK_BIT] = ent[v][dct_pkg::LOCK_BIT];
          next_r.pend = advance_fifo(put_way(rd_data, v, e), v);
          next_r.vway = v;
          next_r.old_physical_tag_field = ent[v][dct_pkg::PHYSICAL_TAG_FIELD_LSB +: dct_pkg::PHYSICAL_TAG_FIELD_W];
          next_r.resp_hit = 1'b0;
          next_r.resp_way = v;
          next_r.resp_ways = '0;
          if (is_valid(ent[v]) && ent[v][dct_pkg::WB_BIT])
          begin
            next_r.st = dct_pkg::ST_WB;
          end
          else
          begin
            next_r.st = dct_pkg::ST_FILL;
          end
        end
      end
      dct_pkg::ST_WB:
      begin
        if (wb_done)
        begin
          if (r.op == dct_pkg::OP_INDEX_WB_INV)
          begin
            next_r.st = dct_pkg::ST_UPD;
          end
          else
          begin
            next_r.st = dct_pkg::ST_FILL;
          end
        end
      end
      dct_pkg::ST_FILL:
      begin
        if (fill_word_valid)
        begin
          next_r.cnt = r.cnt + 3'h1;
          if (r.cnt == 3'(dct_pkg::LINE_WORDS - 1))
          begin
            next_r.st = dct_pkg::ST_UPD;
          end
        end
      end
      dct_pkg::ST_UPD:
      begin
        wr_en = 1'b1;
        next_r.resp_valid = 1'b1;
        next_r.mem_write = r.wr && r.wt && r.op == dct_pkg::OP_NONE;
        next_r.st = dct_pkg::ST_IDLE;
      end
      default:
      begin
        next_r.st = dct_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= dct_pkg::ST_CLEAR;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign req_ready = r.st == dct_pkg::ST_IDLE;
  assign resp_valid = r.resp_valid;
  assign resp_hit = r.resp_hit;
  assign resp_way = r.resp_way;
  assign resp_store_ways = r.resp_ways;
  assign mem_write = r.mem_write;
  assign wb_req = r.st == dct_pkg::ST_WB;
  assign wb_way = r.vway;
  assign wb_index = r.idx;
  assign wb_physical_tag_field = r.old_physical_tag_field;
  assign fill_req = r.st == dct_pkg::ST_FILL;
  assign fill_way = r.vway;
  assign fill_index = r.idx;
  assign fill_physical_tag_field = r.physical_tag_field;
  assign fill_word_sel = r.cnt;
endmodule : dct_tag_ctrl

// ---- rtl/dct_pkg.sv ----
// Constants and types for the data cache tag, lock and replacement logic.
// Assumes one pipeline clock and that every user of it names dct_pkg:: explicitly.
package dct_pkg;
  localparam int IDX_W      = 8;
  localparam int DEPTH      = 256;
  localparam int PHYSICAL_TAG_FIELD_W     = 24;
  localparam int WAYS       = 4;
  localparam int LINE_WORDS = 8;
  localparam int CNT_W      = 3;
  localparam int VA_W       = 13;
  localparam int IDX_LSB    = 5;
  localparam int WORD_LSB   = 3;
  localparam int PA_TAG_LSB = 12;
  localparam int PA_W       = 36;
  // Generic way entry: physical_tag_field, lock, write-back, state
  localparam int WAY_W      = 28;
  localparam int WAY0_W     = 27;
  localparam int CS_LSB     = 0;
  localparam int WB_BIT     = 2;
  localparam int LOCK_BIT   = 3;
  localparam int PHYSICAL_TAG_FIELD_LSB   = 4;
  // One memory word per set
  localparam int WAY1_LSB   = 27;
  localparam int WAY2_LSB   = 55;
  localparam int WAY3_LSB   = 83;
  localparam int FIFO_PTR_LOW_BIT  = 111;
  localparam int FIFO_PTR_HIGH_BIT = 112;
  localparam int SET_W      = 113;
  localparam logic [1:0] CS_INVALID = 2'h0;
  localparam logic [1:0] CS_VALID   = 2'h3;
  localparam logic [1:0] FIFO_RESET = 2'h0;
  // Maintenance operations
  localparam logic [2:0] OP_NONE            = 3'h0;
  localparam logic [2:0] OP_INDEX_WB_INV    = 3'h1;
  localparam logic [2:0] OP_INDEX_STORE_TAG = 3'h2;
  localparam logic [2:0] OP_HIT_INV         = 3'h4;
  localparam logic [2:0] OP_FILL            = 3'h7;

  typedef enum logic [2:0] {
    ST_CLEAR = 3'h0,
    ST_IDLE  = 3'h1,
    ST_LOOK  = 3'h3,
    ST_WB    = 3'h2,
    ST_FILL  = 3'h6,
    ST_UPD   = 3'h7
  } dct_state_t;
endpackage : dct_pkg

// ---- rtl/dct_tag_ram.sv ----
// Simple dual-port tag memory, one word per cache set.
// Assumes write and read of one address never fall in the same cycle.
module dct_tag_ram #(
  parameter int WIDTH = 113,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    // Registered read keeps the compare path off the memory output
    if (rd_en)
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : dct_tag_ram

// ---- bench/dct_tag_ctrl_sva.sv ----
// Port checker for the data cache tag controller.
// Assumes one clock and a synchronous active-high sys_rst.
module dct_tag_ctrl_sva (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       req_write,
  input wire logic       req_write_through,
  input wire logic       req_write_allocate,
  input wire logic [2:0] req_op,
  input wire logic       resp_valid,
  input wire logic       resp_hit,
  input wire logic [1:0] resp_way,
  input wire logic [3:0] resp_store_ways,
  input wire logic       mem_write,
  input wire logic       wb_req,
  input wire logic       wb_done,
  input wire logic       fill_req,
  input wire logic       fill_word_valid,
  input wire logic [2:0] fill_word_sel
);
  logic [8:0] clr_cnt;
  logic [3:0] words;
  logic       wt_seen;
  logic       taken;
  assign taken = req_valid && req_ready;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clr_cnt <= 9'h000;
      words   <= 4'h0;
      wt_seen <= 1'b0;
    end
    else
    begin
      if (clr_cnt != 9'h1ff)
        clr_cnt <= clr_cnt + 9'h001;
      if (!fill_req)
        words <= 4'h0;
      else if (fill_word_valid)
        words <= words + 4'h1;
      if (taken)
        wt_seen <= req_write_through;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_clear_time: assert property (req_ready |-> clr_cnt >= 9'h100)
    else $error("ready before tag clear finished");
  chk_fill_burst: assert property ($fell(fill_req) |-> words == 4'h8)
    else $error("refill burst not eight words");
  chk_word_step: assert property (fill_req && fill_word_valid && fill_word_sel != 3'h7
    |=> fill_word_sel == $past(fill_word_sel) + 3'h1)
    else $error("word select did not advance");
  chk_wb_first: assert property (wb_req |-> !fill_req)
    else $error("fill overlaps write-back");
  chk_wb_hold: assert property (wb_req && !wb_done |=> wb_req)
    else $error("write-back dropped early");
  chk_wt_answer: assert property (taken && req_op == dct_pkg::OP_NONE && req_write
    && req_write_through && !req_write_allocate |-> ##2 (resp_valid && mem_write))
    else $error("write-through store not sent to memory");
  chk_wb_no_mem: assert property (resp_valid && mem_write |-> wt_seen)
    else $error("memory write on write-back page");
  chk_op_fast: assert property (taken && req_op == dct_pkg::OP_INDEX_STORE_TAG
    |-> ##2 resp_valid)
    else $error("tag store not answered in two cycles");
  chk_low_way: assert property (resp_valid && resp_hit |-> resp_store_ways[resp_way]
    && ((resp_store_ways & ((4'h1 << resp_way) - 4'h1)) == 4'h0))
    else $error("hit way not lowest hitting way");
  cover property (resp_valid && resp_hit);
  cover property ($rose(wb_req));
  cover property (resp_valid && mem_write);
endmodule : dct_tag_ctrl_sva

bind dct_tag_ctrl dct_tag_ctrl_sva u_sva (.clk, .sys_rst, .req_valid, .req_ready, .req_write,
  .req_write_through, .req_write_allocate, .req_op, .resp_valid, .resp_hit, .resp_way,
  .resp_store_ways, .mem_write, .wb_req, .wb_done, .fill_req, .fill_word_valid,
  .fill_word_sel);

// ---- bench/dct_bus_model.sv ----
// System bus side model: eight-word refills and write-back completion.
// Assumes fill_req and wb_req are levels held until answered.
module dct_bus_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic fill_req,
  output logic     fill_word_valid,
  input wire logic wb_req,
  output logic     wb_done
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] words;
  logic [3:0] wb_cnt;
  logic       go;
  assign go = (words < 4'h8) && !(slow && fill_word_valid);
  always @(posedge clk)
  begin
    if (sys_rst || !fill_req)
    begin
      words           <= 4'h0;
      fill_word_valid <= 1'b0;
    end
    else
    begin
      // Whole line only, paced one or two cycles a word
      fill_word_valid <= go;
      words           <= words + {3'h0, go};
    end
    if (sys_rst || !wb_req)
      wb_cnt <= 4'h0;
    else if (wb_cnt != 4'hf)
      wb_cnt <= wb_cnt + 4'h1;
    // One pulse per request; slow mode stretches the wait
    wb_done <= wb_req && !sys_rst && (wb_cnt == (slow ? 4'h6 : 4'h2));
  end
endmodule : dct_bus_model

// ---- bench/dct_tag_ctrl_test.sv ----
// Self-checking bench for the data cache tag controller.
// Assumes the bus model answers refills and write-backs.
module dct_tag_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [12:0] req_vaddr = 13'h0000;
  logic [35:0] req_paddr = 36'h000000000;
  logic        req_write_through = 1'b0;
  logic        req_write_allocate = 1'b0;
  logic [2:0]  req_op = 3'h0;
  logic [1:0]  req_op_way = 2'h0;
  logic [27:0] tag_staging_register = 28'h0000000;
  logic        slow = 1'b0;
  logic        req_ready, resp_valid, resp_hit, mem_write, wb_req, wb_done;
  logic        fill_req, fill_word_valid;
  logic [1:0]  resp_way, wb_way, fill_way;
  logic [3:0]  resp_store_ways;
  logic [7:0]  wb_index, fill_index;
  logic [23:0] wb_physical_tag_field, fill_physical_tag_field;
  logic [2:0]  fill_word_sel;
  logic        r_mw;
  logic [33:0] wb_cap, fill_cap;
  logic        wb_seen = 1'b0;
  int          err_count = 0;
  int          cmp_count = 0;
  int          lat;
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (wb_req === 1'b1)
    begin
      wb_seen <= 1'b1;
      wb_cap  <= {wb_way, wb_index, wb_physical_tag_field};
    end
    if (fill_req === 1'b1)
      fill_cap <= {fill_way, fill_index, fill_physical_tag_field};
  end
  dct_tag_ctrl u_dut (.clk, .sys_rst, .req_valid, .req_ready, .req_write, .req_vaddr,
    .req_paddr, .req_write_through, .req_write_allocate, .req_op, .req_op_way,
    .tag_staging_register, .resp_valid, .resp_hit, .resp_way, .resp_store_ways, .mem_write,
    .wb_req, .wb_done, .wb_way, .wb_index, .wb_physical_tag_field, .fill_req, .fill_word_valid, .fill_way,
    .fill_index, .fill_physical_tag_field, .fill_word_sel);
  dct_bus_model u_bus (.clk, .sys_rst, .slow, .fill_req, .fill_word_valid, .wb_req, .wb_done);
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (err_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude
  // Request held until taken; returns on the edge after the answer
  task automatic go(input logic w, input logic [7:0] ix, input logic [23:0] tg,
                    input logic [2:0] op);
    req_write = w;
    req_vaddr = {ix, 5'h00};
    req_paddr = {tg[22:0], ix[7], 12'h000};
    req_op = op;
    req_valid = 1'b1;
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    #1 req_valid = 1'b0;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
    end while (resp_valid !== 1'b1 && lat < 500);
    if (lat >= 500)
    begin
      err_count++;
      conclude();
    end
    r_mw = mem_write;
    @(posedge clk);
    #1;
  endtask : go
  task automatic ld(input logic [7:0] ix, input logic [23:0] tg, input logic h,
                    input logic [1:0] way);
    go(1'b0, ix, tg, dct_pkg::OP_NONE);
    check("hit", resp_hit, h);
    check("way", resp_way, way);
  endtask : ld
  task automatic tag_op(input logic [1:0] way, input logic [23:0] tg, input logic lk,
                        input logic [1:0] cs, input logic [7:0] ix);
    tag_staging_register = {tg[22:0], ix[7], lk, 1'b0, cs};
    req_op_way = way;
    go(1'b0, ix, 24'h000000, dct_pkg::OP_INDEX_STORE_TAG);
    check("op_lat", lat, 2);
  endtask : tag_op
  task automatic t_reset;
    int n = 0;
    do
    begin
      @(posedge clk);
      #1 n++;
    end while (req_ready !== 1'b1 && n < 400);
    check("ready_edge", n, 256);
  endtask : t_reset
  task automatic t_fifo;
    for (int i = 0; i < 4; i++)
      ld(8'h10, 24'(i + 1), 1'b0, 2'(i));
    ld(8'h10, 24'h000003, 1'b1, 2'h2);
    ld(8'h10, 24'h400003, 1'b0, 2'h0);
  endtask : t_fifo
  task automatic t_dirty;
    go(1'b1, 8'h10, 24'h000002, dct_pkg::OP_NONE);
    check("st_hit", resp_hit, 1'b1);
    check("st_mw", r_mw, 1'b0);
    slow = 1'b1;
    wb_seen = 1'b0;
    ld(8'h10, 24'h000005, 1'b0, 2'h1);
    check("wb_seen", wb_seen, 1'b1);
    check("wb_physical_tag_field", wb_cap[23:0], 24'h000004);
    check("wb_loc", wb_cap[33:24], {2'h1, 8'h10});
    check("fill_physical_tag_field", fill_cap[23:0], 24'h00000a);
    check("fill_loc", fill_cap[33:24], {2'h1, 8'h10});
    slow = 1'b0;
  endtask : t_dirty
  task automatic t_wt;
    req_write_through = 1'b1;
    go(1'b1, 8'h20, 24'h000007, dct_pkg::OP_NONE);
    check("wt_lat", lat, 2);
    check("wt_mw", r_mw, 1'b1);
    req_write_through = 1'b0;
    ld(8'h20, 24'h000007, 1'b0, 2'h0);
    req_write_through = 1'b1;
    req_write_allocate = 1'b1;
    go(1'b1, 8'h20, 24'h000008, dct_pkg::OP_NONE);
    check("wta_mw", r_mw, 1'b1);
    check("wta_way", resp_way, 2'h1);
    req_write_through = 1'b0;
    req_write_allocate = 1'b0;
    ld(8'h20, 24'h000008, 1'b1, 2'h1);
  endtask : t_wt
  // Way 1 locked valid: the pointer must step over it
  task automatic t_lock;
    logic [1:0] v[4] = '{2'h2, 2'h3, 2'h0, 2'h2};
    for (int i = 0; i < 4; i++)
      ld(8'h30, 24'(i + 1), 1'b0, 2'(i));
    tag_op(2'h1, 24'h00000b, 1'b1, dct_pkg::CS_VALID, 8'h30);
    for (int i = 0; i < 4; i++)
      ld(8'h30, 24'(i + 5), 1'b0, v[i]);
    ld(8'h30, 24'h00000b, 1'b1, 2'h1);
    req_write_through = 1'b1;
    go(1'b1, 8'h30, 24'h00000b, dct_pkg::OP_NONE);
    check("lk_wt_mw", r_mw, 1'b1);
    req_write_through = 1'b0;
    go(1'b1, 8'h30, 24'h00000b, dct_pkg::OP_NONE);
    check("lk_wb_mw", r_mw, 1'b0);
    ld(8'h30, 24'h00000b, 1'b1, 2'h1);
    tag_op(2'h1, 24'h00000b, 1'b0, dct_pkg::CS_VALID, 8'h30);
    req_write_through = 1'b1;
    go(1'b1, 8'h30, 24'h00000b, dct_pkg::OP_NONE);
    check("flush_mw", r_mw, 1'b1);
    req_write_through = 1'b0;
    for (int i = 0; i < 4; i++)
      ld(8'h30, 24'(i + 17), 1'b0, 2'(i + 2));
  endtask : t_lock
  task automatic t_multi;
    tag_op(2'h1, 24'h00000c, 1'b0, dct_pkg::CS_VALID, 8'h40);
    tag_op(2'h2, 24'h00000c, 1'b0, dct_pkg::CS_VALID, 8'h40);
    tag_op(2'h3, 24'h00000c, 1'b0, dct_pkg::CS_INVALID, 8'h40);
    ld(8'h40, 24'h00000c, 1'b1, 2'h1);
    check("ld_ways", resp_store_ways, 4'h6);
    go(1'b1, 8'h40, 24'h00000c, dct_pkg::OP_NONE);
    check("st_ways", resp_store_ways, 4'h6);
    go(1'b0, 8'h40, 24'h00000c, dct_pkg::OP_HIT_INV);
    check("hinv_lat", lat, 2);
    ld(8'h40, 24'h00000c, 1'b0, 2'h2);
    go(1'b1, 8'h40, 24'h00000c, dct_pkg::OP_NONE);
    req_op_way = 2'h2;
    wb_seen = 1'b0;
    go(1'b0, 8'h40, 24'h000000, dct_pkg::OP_INDEX_WB_INV);
    check("wbi_seen", wb_seen, 1'b1);
    check("wbi_physical_tag_field", wb_cap[23:0], 24'h000018);
    check("wbi_loc", wb_cap[33:24], {2'h2, 8'h40});
    ld(8'h40, 24'h00000c, 1'b0, 2'h3);
  endtask : t_multi
  // Lock staged on an invalid way, then a fill op claims it
  task automatic t_fill_lock;
    logic [1:0] v[4] = '{2'h0, 2'h1, 2'h2, 2'h0};
    tag_op(2'h3, 24'h000000, 1'b1, dct_pkg::CS_INVALID, 8'h50);
    for (int i = 0; i < 3; i++)
      ld(8'h50, 24'(i + 1), 1'b0, 2'(i));
    go(1'b0, 8'h50, 24'h00000d, dct_pkg::OP_FILL);
    check("fill_way", resp_way, 2'h3);
    for (int i = 0; i < 4; i++)
      ld(8'h50, 24'(i + 4), 1'b0, v[i]);
    ld(8'h50, 24'h00000d, 1'b1, 2'h3);
  endtask : t_fill_lock
  initial
  begin
    #200000;
    err_count++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset();
    t_fifo();
    t_dirty();
    t_wt();
    t_lock();
    t_multi();
    t_fill_lock();
    conclude();
  end
endmodule : dct_tag_ctrl_test
